// File: design/adp_regs.sv
/*
  Register block of an 8-bit multi-channel converter peripheral on an
  8-bit parallel processor bus. Assumes bus controls are asynchronous
  pins and are synchronised here; the analog comparator is synchronous.
*/
`timescale 1ns/10ps
module adp_regs
  import adp_pkg::*;
(
  input  wire logic        clk,          // 25 MHz clock
  input  wire logic        rst_n,        // Synchronous reset, active low
  input  wire logic        cs_n,         // Chip select pin, active low
  input  wire logic        rw,           // High read, low write
  input  wire logic        register_select, // Low result, high pins
  input  wire logic [7:0]  db_in,        // Data bus from processor
  output logic      [7:0]  db_out,       // Data bus to processor
  output logic             db_oe_n,      // Bus drive enable, active low
  input  wire logic [5:0]  shared_port_bits, // Shared pin levels
  input  wire logic        cmp_hi,       // Comparator result
  output logic      [7:0]  trial,        // Trial code to the DAC
  output logic      [4:0]  mux_sel,      // Multiplexer input number
  output logic             acquiring     // Sample switch closed
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [9:0] s1_reg, s2_reg;            // Two stages each
  logic [5:0] pin_reg;                    // Pin level stage two
  logic [5:0] pin1_reg;                   // Pin level stage one
  always_ff @(posedge clk) begin
    s1_reg   <= {cs_n, rw, register_select, db_in[7:1]};
    s2_reg   <= s1_reg;
    pin1_reg <= shared_port_bits;
    pin_reg  <= pin1_reg;
  end
  logic [7:0] db_s;                       // Bus data, bit 0 separate
  logic       d0a_reg, d0b_reg;
  always_ff @(posedge clk) begin
    d0a_reg <= db_in[0];
    d0b_reg <= d0a_reg;
  end
  assign db_s = {s2_reg[6:0], d0b_reg};
  logic cs_s, rw_s, rs_s;                 // Synchronised controls
  assign cs_s = !s2_reg[9];
  assign rw_s = s2_reg[8];
  assign rs_s = s2_reg[7];

  // Channel decode, used for the multiplexer
  function automatic logic [4:0] chan_decode(input logic [3:0] c);
    unique case (c)
      4'h0: chan_decode = 5'h00;
      4'h1: chan_decode = MUX_SELF;
      4'h2, 4'h3, 4'h4, 4'h5: chan_decode = {1'b0, c};
      4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: chan_decode = {1'b0, c};
      default: chan_decode = MUX_NONE;          // Codes 6..9 unused
    endcase
  endfunction

  adp_conv_if cif ();

  // ****************************************
  // Bus front end state
  // ****************************************
  logic       ls_ptr_reg, ls_ptr_next;   // Byte pointer: 1 = LS byte
  logic       first_reg, first_next;     // LS byte still to be taken
  logic       start_bit_reg, start_bit_next; // Start bit held from MS command byte
  logic [3:0] chan_reg, chan_next;       // Channel in effect
  logic       done_reg, done_next;       // Done flag
  logic [7:0] result_reg, result_next;   // Latest result
  logic       go_reg, go_next;           // Start pulse to sequencer
  logic [7:0] dout_reg, dout_next;       // Bus output data
  logic       oe_reg, oe_next;           // Bus drive, active high here

  logic [15:0] conv_word, pin_word;      // Readable words
  assign conv_word = {done_reg, 7'h00, result_reg};
  assign pin_word  = {pin_reg, chan_reg, 6'h00};

  // Next values of the front end
  always_comb begin
    ls_ptr_next    = ls_ptr_reg;
    first_next     = first_reg;
    start_bit_next = start_bit_reg;
    chan_next      = chan_reg;
    done_next      = done_reg;
    result_next    = result_reg;
    go_next        = 1'b0;
    dout_next      = dout_reg;
    oe_next        = 1'b0;
    if (!cs_s) begin
      ls_ptr_next = 1'b0;                // back to MS byte
      first_next  = 1'b1;
    end else if (!ls_ptr_reg) begin
      ls_ptr_next = 1'b1;                // MS taken, move to LS
      if (!rw_s) begin                   // write command
        start_bit_next = db_s[START_BIT_POS-8];
      end
    end else if (first_reg) begin
      first_next = 1'b0;                 // Later bytes are ignored
      if (!rw_s) begin                   // LS byte commits
        chan_next = db_s[CHAN_LSB_POS +: CHAN_W];
        done_next = 1'b0;
        go_next   = start_bit_reg;
      end
    end
    if (cs_s && rw_s) begin              // read path
      oe_next   = 1'b1;
      dout_next = rs_s ? (ls_ptr_reg ? pin_word[7:0]  : pin_word[15:8])
                       : (ls_ptr_reg ? conv_word[7:0] : conv_word[15:8]);
    end
    if (cif.done) begin
      result_next = cif.result;
      done_next   = 1'b1;                // set wins over clear
    end
  end

  // Registers; result survives reset
  always_ff @(posedge clk) begin
    result_reg  <= result_next;          // keeps result
    done_reg    <= done_next;            // status word kept too
    if (!rst_n) begin
      ls_ptr_reg    <= 1'b0;
      first_reg     <= 1'b1;
      start_bit_reg <= 1'b0;             // clear start bit
      chan_reg      <= CHAN_RST;
      go_reg        <= 1'b0;
      dout_reg      <= 8'h00;
      oe_reg        <= 1'b0;             // float outputs
    end else begin
      ls_ptr_reg    <= ls_ptr_next;
      first_reg     <= first_next;
      start_bit_reg <= start_bit_next;
      chan_reg      <= chan_next;
      go_reg        <= go_next;
      dout_reg      <= dout_next;
      oe_reg        <= oe_next;
    end
  end

  assign cif.start   = go_reg;
  assign cif.mux_sel = chan_decode(chan_reg);
  assign mux_sel     = cif.mux_sel;
  assign acquiring   = cif.acquiring;
  assign db_out      = dout_reg;
  assign db_oe_n     = !oe_reg;

  adp_seq u_seq (
    .clk    (clk),
    .rst_n  (rst_n),
    .cif    (cif),
    .cmp_hi (cmp_hi),
    .trial  (trial)
  );

  // Done is set by a finish pulse
  property p_done_set;
    @(posedge clk) disable iff (!rst_n) cif.done |=> done_reg;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag not set");

  // Done only falls after an LS write
  property p_done_clr;
    @(posedge clk) disable iff (!rst_n)
      $fell(done_reg) |-> $past(ls_ptr_reg && !rw_s && cs_s);
  endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("done cleared without full write");

  // Start pulse follows LS write with start bit set
  property p_start;
    @(posedge clk) disable iff (!rst_n)
      go_reg |-> $past(start_bit_reg && ls_ptr_reg && !rw_s);
  endproperty
  a_start: assert property (p_start)
    else $error("start without command");

  // Bus floats outside a read
  property p_float;
    @(posedge clk) disable iff (!rst_n)
      !(cs_s && rw_s) |=> db_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("bus driven outside read");

  // MS byte of result word shows only done
  property p_ms_zero;
    @(posedge clk) disable iff (!rst_n)
      (cs_s && rw_s && !rs_s && !ls_ptr_reg) |=>
        db_out[6:0] == 7'h00;
  endproperty
  a_ms_zero: assert property (p_ms_zero)
    else $error("status byte not clean");

endmodule

// File: design/adp_seq.sv
/*
  Conversion sequencer: acquisition then successive approximation.
  Assumes the comparator input is synchronous to clk and that the
  analog side answers each trial within one cycle.
*/
`timescale 1ns/10ps
module adp_seq
  import adp_pkg::*;
(
  input  wire logic         clk,     // 25 MHz clock
  input  wire logic         rst_n,   // Synchronous reset, active low
  adp_conv_if.seq           cif,     // Link to register front end
  input  wire logic         cmp_hi,  // Comparator: input above trial
  output logic [7:0]        trial    // Trial code to the DAC
);

  // ****************************************
  // Sequencer state
  // ****************************************
  adp_state_e state_reg, state_next;   // Sequencer state
  logic [4:0] cnt_reg, cnt_next;       // Cycles since start
  logic [7:0] sar_reg, sar_next;       // Approximation register
  logic [7:0] bit_reg, bit_next;       // Bit under trial
  logic       done_reg, done_next;     // Finish pulse

  localparam logic [4:0] LAST = 5'(CONV_CYCLES - 1);
  localparam logic [4:0] ACQ_LAST = 5'(ACQ_CYCLES - 1);
  // Twenty SAR cycles for eight bits: a bit steps every other cycle
  // from cycle 15 on, leaving settle time for the comparator.

  // Next state
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sar_next   = sar_reg;
    bit_next   = bit_reg;
    done_next  = 1'b0;
    if (cif.start) begin                      // abandon and restart
      state_next = ADP_ACQ;
      cnt_next   = 5'h00;
      sar_next   = 8'h00;
      bit_next   = 8'h80;
    end else begin
      unique case (state_reg)
        ADP_IDLE: begin
          cnt_next = 5'h00;
        end
        ADP_ACQ: begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == ACQ_LAST) begin
            state_next = ADP_SAR;
          end
        end
        ADP_SAR: begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg >= 5'd14 && cnt_reg[0] && bit_reg != 8'h00) begin
            if (cmp_hi) begin
              sar_next = sar_reg | bit_reg;   // keep the bit under trial
            end
            bit_next = bit_reg >> 1;
          end
          if (cnt_reg == LAST) begin
            state_next = ADP_IDLE;
            done_next  = 1'b1;
          end
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin                         // idle converter
      state_reg <= ADP_IDLE;
      cnt_reg   <= 5'h00;
      sar_reg   <= 8'h00;
      bit_reg   <= 8'h00;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sar_reg   <= sar_next;
      bit_reg   <= bit_next;
      done_reg  <= done_next;
    end
  end

  assign trial         = sar_reg | bit_reg;
  assign cif.acquiring = (state_reg == ADP_ACQ);
  assign cif.done      = done_reg;
  assign cif.result    = sar_reg;

  // Done comes 31 cycles after the start pulse
  property p_conv_len;
    @(posedge clk) disable iff (!rst_n)
      cif.start ##1 (!cif.start)[*8] ##1 (!cif.start)[*8]
        ##1 (!cif.start)[*8] ##1 (!cif.start)[*6] |=> done_reg;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion did not take 30 cycles");

  // Acquisition lasts exactly ten cycles
  property p_acq_len;
    @(posedge clk) disable iff (!rst_n)
      cif.start ##1 (!cif.start)[*8] ##1 (!cif.start)[*2]
        |-> (state_reg == ADP_ACQ) ##1 (state_reg == ADP_SAR);
  endproperty
  a_acq_len: assert property (p_acq_len)
    else $error("acquisition not ten cycles");

  // A new command restarts acquisition
  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      cif.start |=> state_reg == ADP_ACQ && cnt_reg == 5'h00;
  endproperty
  a_restart: assert property (p_restart)
    else $error("command did not restart acquisition");

endmodule

// File: pkg/adp_conv_if.sv
/*
  Interface between the register front end and the conversion sequencer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface adp_conv_if;
  import adp_pkg::*;
  logic                start;     // One-cycle conversion command
  logic [4:0]          mux_sel;   // Decoded multiplexer input
  logic                acquiring; // Sample switch closed
  logic                done;      // One-cycle finish pulse
  logic [RESULT_W-1:0] result;    // Result at the finish pulse
  modport front (output start, output mux_sel, input acquiring,
                 input done, input result);
  modport seq   (input start, input mux_sel, output acquiring,
                 output done, output result);
endinterface

// File: pkg/adp_pkg.sv
/*
  Package for the parallel-bus converter peripheral register block.
  Holds register field positions, the multiplexer input numbers, the conversion
  timing and the state encoding. Assumes one 25 MHz clock domain.
*/
package adp_pkg;

  // ****************************************
  // Command word fields (two-byte write)
  // ****************************************
  localparam int START_BIT_POS = 15;      // Start bit, top of MS byte
  localparam int CHAN_LSB_POS  = 0;       // Channel field, LS byte low
  localparam int CHAN_W        = 4;       // Channel field width

  // ****************************************
  // Result word fields
  // ****************************************
  localparam int DONE_BIT_POS  = 15;      // Done flag, top of MS byte
  localparam int RESULT_W      = 8;       // Result width

  // ****************************************
  // Pin level word fields
  // ****************************************
  localparam int PORT_W        = 6;       // Shared pin count
  localparam int PORT_LSB_POS  = 10;      // Pins in MS byte bits 15..10
  localparam int PCHAN_LSB_POS = 6;       // Channel in bits 9..6

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RESULT_RST = 8'h00;  // Unused; result_reg takes no power-up value
  localparam logic [3:0] CHAN_RST   = 4'h0;   // Channel after reset

  // ****************************************
  // Timing, in converter clock cycles
  // ****************************************
  localparam int CONV_CYCLES = 30;        // Whole conversion
  localparam int ACQ_CYCLES  = 10;        // Acquisition part of it
  localparam int RESET_HOLD  = 3;         // Least reset hold cycles

  // ****************************************
  // Multiplexer input numbers
  // ****************************************
  localparam logic [4:0] MUX_NONE  = 5'h1F; // Unused code, no input
  localparam logic [4:0] MUX_SELF  = 5'h10; // Upper reference self-test

  // Converter sequencer states, one-hot
  typedef enum logic [2:0] {
    ADP_IDLE = 3'b001,
    ADP_ACQ  = 3'b010,
    ADP_SAR  = 3'b100
  } adp_state_e;

endpackage

// File: sim/adc_peripheral_registers_bench.sv
/*
  Self-checking bench for the converter register block.
  Assumes the analog model above and pin synchronisers of two cycles.
*/
`timescale 1ns/10ps
module adc_peripheral_registers_bench;
  import adp_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic       clk = 1'b0;          // 25 MHz clock
  logic       rst_n;               // Reset, active low
  logic       cs_n;                // Chip select, active low
  logic       rw;                  // High read, low write
  logic       register_select;     // Low result, high pins
  logic [7:0] db_in;               // Bus data to the block
  logic [7:0] db_out;              // Bus data from the block
  logic       db_oe_n;             // Block drives bus when low
  logic [5:0] shared_port_bits;    // Shared pin levels
  logic       cmp_hi;              // Comparator answer
  logic [7:0] trial;               // Trial code
  logic [4:0] mux_sel;             // Input number
  logic       acquiring;           // Sample switch closed
  int         n_errors;            // Mismatch count
  int         compares;            // Comparison count
  int         cycles = 0;          // Run length so far
  logic [7:0] hi;                  // MS byte read
  logic [7:0] lo;                  // LS byte read

  always #20 clk = ~clk;

  adp_regs dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rw(rw),
    .register_select(register_select), .db_in(db_in), .db_out(db_out),
    .db_oe_n(db_oe_n), .shared_port_bits(shared_port_bits),
    .cmp_hi(cmp_hi), .trial(trial), .mux_sel(mux_sel),
    .acquiring(acquiring));
  adp_analog_model u_analog (.trial(trial), .mux_sel(mux_sel),
    .cmp_hi(cmp_hi));

  // ****************************************
  // Tasks
  // ****************************************
  // Inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Word write, MS byte first; one byte when nb is 1
  task automatic wr(input logic [7:0] h, input logic [7:0] l,
                    input int nb);
    cs_n = 1'b0;
    rw = 1'b0;
    db_in = h;
    tick(1);
    if (nb > 1) begin
      db_in = l;
      tick(1);
    end
    cs_n = 1'b1;
    rw = 1'b1;
    db_in = ~db_in;                // Released bus shows no stale byte
    tick(1);
  endtask

  // Read waits for the block to drive, bounded
  task automatic rd(input logic sel, input int nb);
    int w;
    cs_n = 1'b0;
    rw = 1'b1;
    register_select = sel;
    w = 0;
    tick(1);
    while (db_oe_n !== 1'b0 && w < 20) begin
      tick(1);
      w++;
    end
    if (w >= 20) begin
      check(8'h00, 8'h01);         // Never drove the bus
    end
    hi = db_out;
    lo = 8'h00;
    if (nb > 1) begin
      tick(1);
      lo = db_out;
    end
    cs_n = 1'b1;
    tick(3);
  endtask

  // Start a conversion, time it, read the outcome
  task automatic conv(input logic [3:0] c, input logic [7:0] exp);
    int n;
    wr(8'h80, {4'h0, c}, 2);
    n = 0;
    while (acquiring !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    n = 0;
    while (acquiring === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    check(n[7:0], ACQ_CYCLES[7:0]);
    rd(1'b0, 1);
    check(hi, 8'h00);
    tick(CONV_CYCLES - ACQ_CYCLES);
    rd(1'b0, 2);
    check(hi, 8'h80);
    check(lo, exp);
  endtask

  function automatic logic [7:0] dec(input logic [3:0] c);
    if (c == 4'h1) return {3'h0, MUX_SELF};
    if (c >= 4'h6 && c <= 4'h9) return {3'h0, MUX_NONE};
    return {4'h0, c};
  endfunction

  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  // Whole sequence needs about 400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      n_errors++;
      end_of_test();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    cs_n = 1'b1;
    rw = 1'b1;
    register_select = 1'b0;
    db_in = 8'h00;
    shared_port_bits = 6'h2A;
    n_errors = 0;
    compares = 0;
    tick(3);
    check({7'h00, db_oe_n}, 8'h01);
    rst_n = 1'b1;
    tick(2);
    // Every channel code, unused command bits all set, back to back
    for (int k = 0; k < 16; k++) begin
      wr(8'hFF, {4'hF, k[3:0]}, 2);
      tick(3);
      check({3'h0, mux_sel}, dec(k[3:0]));
      check({7'h00, acquiring}, 8'h01);
    end
    tick(40);
    conv(4'h1, 8'hFF);             // Self-test at full scale
    conv(4'hA, 8'hAA);
    wr(8'h00, 8'h00, 1);           // One byte leaves done alone
    tick(3);
    rd(1'b0, 1);
    check(hi, 8'h80);
    wr(8'h80, 8'h0A, 2);
    rd(1'b0, 1);
    check(hi, 8'h00);
    rd(1'b1, 2);
    check(hi, 8'hAA);
    check({lo[7:6], 6'h00}, 8'h80);
    shared_port_bits = 6'h15;
    tick(4);
    rd(1'b1, 1);
    check(hi, 8'h56);
    tick(40);
    // Reset mid-run keeps the last result
    rst_n = 1'b0;
    tick(3);
    check({6'h00, db_oe_n, acquiring}, 8'h02);
    rst_n = 1'b1;
    tick(2);
    rd(1'b0, 2);
    check(lo, 8'hAA);
    check(hi, 8'h80);
    // Second command in mid approximation wins
    wr(8'h80, 8'h02, 2);
    tick(20);
    conv(4'h3, 8'h33);
    end_of_test();
  end
endmodule

// File: sim/adp_analog_model.sv
/*
  Analog side model: multiplexed input levels and the comparator.
  Assumes the trial code and input number come from the register block
  on the same clock, and that the comparator answers within one cycle.
*/
`timescale 1ns/10ps
module adp_analog_model
  import adp_pkg::*;
(
  input  wire logic [7:0] trial,   // Trial code from the DAC
  input  wire logic [4:0] mux_sel, // Selected input number
  output logic            cmp_hi   // High when input above trial
);
  // ****************************************
  // Input levels and comparison
  // ****************************************
  logic [7:0] level;               // Level of the selected input

  // Self-test sits at the upper reference, others repeat their number
  always_comb begin
    if (mux_sel == MUX_SELF) begin
      level = 8'hFF;               // Full scale
    end else begin
      level = {mux_sel[3:0], mux_sel[3:0]};
    end
    // Half a step above level, so the code settles exactly on level
    cmp_hi = ({level, 1'b1} > {trial, 1'b0});
  end
endmodule
